/* File: core/rxst_flag_calc.sv */
// rxst_flag_calc: derives the upper statistics flags from one frame summary
`timescale 1ns/1ns
module rxst_flag_calc import rxst_pkg::*; #(
	parameter bit PFC_EN = 1'b0,
	parameter bit FILTER_EN = 1'b1
) (
	// frame summary and controls
	input wire rxst_frame_t frame_i,
	input wire logic len_chk_en_i,
	input wire logic promisc_i,
	// derived flags
	output rxst_flags_t flags_o
);

	// ****************************************
	// flag decode
	// ****************************************
	logic len_mismatch;
	logic short_unpadded;
	logic is_pause;

	// length checks
	assign len_mismatch = len_chk_en_i && frame_i.len_is_length
		&& (frame_i.len_field != frame_i.client_bytes);
	assign short_unpadded = frame_i.len_is_length && (frame_i.len_field < MIN_LEN_FIELD)
		&& (frame_i.frame_bytes != PAD_FRAME_LEN);
	assign is_pause = frame_i.opcode == PAUSE_OPCODE;

	// flag assembly
	always_comb begin
		flags_o.priority_flow_control = PFC_EN && frame_i.pfc_valid;
		flags_o.addr = !FILTER_EN || promisc_i || frame_i.filter_hit;
		flags_o.align = !frame_i.speed_gig && frame_i.odd_nibble && !frame_i.fcs_ok;
		flags_o.len = len_mismatch || short_unpadded;
		flags_o.badop = frame_i.frame_ok && frame_i.ctrl_type && !is_pause;
		flags_o.pause = frame_i.frame_ok && frame_i.ctrl_type && is_pause
			&& (frame_i.da_ctrl_mcast || frame_i.da_station) && frame_i.pause_acted;
	end

endmodule // rxst_flag_calc

/* File: core/rxst_top.sv */
// rxst_top: audio/video receive stream port, receive statistics vector and register slave
`timescale 1ns/1ns
module rxst_top import rxst_pkg::*; #(
	parameter bit PFC_EN = 1'b0,
	parameter bit FILTER_EN = 1'b1,
	parameter int VEC_W = PFC_EN ? RXST_FULL_W : RXST_BASE_W
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// receive engine byte stream and frame summary
	input wire rxst_byte_t eng_byte_i,
	input wire logic eng_byte_active_i,
	input wire logic eng_stats_valid_i,
	input wire rxst_frame_t eng_frame_i,
	// audio/video receive stream
	output logic [7:0] av_rx_byte_out_o,
	output logic av_rx_byte_qualifier_o,
	output logic av_rx_frame_end_o,
	output logic av_rx_frame_error_o,
	// statistics
	output logic [VEC_W-1:0] rx_stats_vector_o,
	output logic rx_stats_valid_o,
	// avalon-mm slave
	input wire logic [AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// interrupt
	output logic irq_o
);

	// ****************************************
	// declarations
	// ****************************************
	logic [1:0] ctrl_r;
	logic [IRQ_W-1:0] status_r;
	logic [IRQ_W-1:0] status_nxt;
	logic [IRQ_W-1:0] mask_r;
	logic [IRQ_W-1:0] event_set;
	logic [31:0] frame_count_r;
	logic [31:0] readdata_nxt;
	logic ack_r;
	logic req;
	logic wr_take;
	logic frame_err_r;
	logic [VEC_W-1:0] stats_r;
	logic [RXST_FULL_W-1:0] vec_full;
	rxst_flags_t flags;

	// register word select, used by read mux and write decode
	function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
		hit = (a[AW-1:2] == off[AW-1:2]);
	endfunction

	// ****************************************
	// avalon-mm slave
	// ****************************************
	// one wait cycle then the answer; request held by master meanwhile
	assign req = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !ack_r;
	assign wr_take = avs_write_i && ack_r;

	// acknowledge pulses on the second cycle of each request
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		readdata_nxt = 32'h00000000;
		if (hit(avs_address_i, REG_CTRL)) begin
			readdata_nxt = {30'h00000000, ctrl_r};
		end else if (hit(avs_address_i, REG_STATUS)) begin
			readdata_nxt = {28'h0000000, status_r};
		end else if (hit(avs_address_i, REG_MASK)) begin
			readdata_nxt = {28'h0000000, mask_r};
		end else if (hit(avs_address_i, REG_STATS)) begin
			readdata_nxt = 32'(stats_r);
		end else if (hit(avs_address_i, REG_COUNT)) begin
			readdata_nxt = frame_count_r;
		end
	end

	// read data captured as waitrequest drops
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && !ack_r) begin
			avs_readdata_o <= readdata_nxt;
		end
	end

	// control register: length check enable and promiscuous mode
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_take && hit(avs_address_i, REG_CTRL) && avs_byteenable_i[0]) begin
			ctrl_r <= avs_writedata_i[1:0];
		end
	end

	// interrupt mask register
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mask_r <= MASK_RST;
		end else if (wr_take && hit(avs_address_i, REG_MASK) && avs_byteenable_i[0]) begin
			mask_r <= avs_writedata_i[IRQ_W-1:0];
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	// events from the statistics strobe and the stream error flag
	always_comb begin
		event_set = '0;
		event_set[IRQ_FRAME] = eng_stats_valid_i;
		event_set[IRQ_ERR] = eng_byte_i.valid && eng_byte_i.last && (eng_byte_i.err || frame_err_r);
		event_set[IRQ_PAUSE] = eng_stats_valid_i && flags.pause;
		event_set[IRQ_BADOP] = eng_stats_valid_i && flags.badop;
	end

	// write one clears; a new event in the same cycle wins
	always_comb begin
		status_nxt = status_r;
		if (wr_take && hit(avs_address_i, REG_STATUS) && avs_byteenable_i[0]) begin
			status_nxt = status_r & ~avs_writedata_i[IRQ_W-1:0];
		end
		status_nxt = status_nxt | event_set;
	end

	// sticky status bits
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// level interrupt from unmasked status
	assign irq_o = |(status_r & mask_r);

	// frames seen counter, wraps
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			frame_count_r <= 32'h00000000;
		end else if (eng_stats_valid_i) begin
			frame_count_r <= frame_count_r + 32'h00000001;
		end
	end

	// ****************************************
	// audio/video stream port
	// ****************************************
	// error seen on any earlier byte of the current frame
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			frame_err_r <= 1'b0;
		end else if (eng_byte_i.valid && eng_byte_i.last) begin
			frame_err_r <= 1'b0;
		end else if (eng_byte_i.valid && eng_byte_i.err) begin
			frame_err_r <= 1'b1;
		end
	end

	// one registered byte per transfer, all controls active high
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			av_rx_byte_out_o <= 8'h00;
			av_rx_byte_qualifier_o <= 1'b0;
			av_rx_frame_end_o <= 1'b0;
			av_rx_frame_error_o <= 1'b0;
		end else begin
			av_rx_byte_out_o <= eng_byte_i.data;
			av_rx_byte_qualifier_o <= eng_byte_i.valid;
			av_rx_frame_end_o <= eng_byte_i.valid && eng_byte_i.last;
			av_rx_frame_error_o <= eng_byte_i.valid && eng_byte_i.last
				&& (eng_byte_i.err || frame_err_r);
		end
	end

	// ****************************************
	// statistics vector
	// ****************************************
	rxst_flag_calc #(
		.PFC_EN(PFC_EN),
		.FILTER_EN(FILTER_EN)
	) u_flag_calc (
		.frame_i(eng_frame_i),
		.len_chk_en_i(ctrl_r[CTL_LENCHK]),
		.promisc_i(ctrl_r[CTL_PROMISC]),
		.flags_o(flags)
	);

	// full vector; the width parameter drops the priority bit when absent
	assign vec_full = {flags.priority_flow_control, flags.addr, flags.align, flags.len, flags.badop, flags.pause,
		eng_byte_active_i, eng_frame_i.low_stats};

	// latched at frame end and held; byte activity refreshed every cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			stats_r <= '0;
		end else begin
			if (eng_stats_valid_i) begin
				stats_r <= vec_full[VEC_W-1:0];
			end
			stats_r[B_BYTE] <= eng_byte_active_i;
		end
	end

	// valid strobe aligned with the latched vector
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rx_stats_valid_o <= 1'b0;
		end else begin
			rx_stats_valid_o <= eng_stats_valid_i;
		end
	end

	assign rx_stats_vector_o = stats_r;

	// ****************************************
	// checks
	// ****************************************
	stream_byte_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$past(eng_byte_i.valid) && !$past(srst_i) |-> av_rx_byte_qualifier_o
		&& av_rx_byte_out_o == $past(eng_byte_i.data))
		else $error("stream byte not passed through");

	stream_last_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!$past(srst_i) |-> av_rx_frame_end_o == $past(eng_byte_i.valid && eng_byte_i.last)
		&& (!av_rx_frame_end_o || av_rx_byte_qualifier_o))
		else $error("frame end flag wrong or without valid byte");

	stream_error_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$past(eng_byte_i.valid && eng_byte_i.last && eng_byte_i.err) && !$past(srst_i)
		|-> av_rx_frame_error_o && av_rx_frame_end_o)
		else $error("errored frame end not flagged");

	stream_user_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		av_rx_frame_error_o |-> av_rx_frame_end_o && av_rx_byte_qualifier_o)
		else $error("error flag outside frame end");

	addr_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		rx_stats_valid_o && (!FILTER_EN || $past(ctrl_r[CTL_PROMISC])) |-> rx_stats_vector_o[B_ADDR])
		else $error("address match not held high");

	addr_match_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i && eng_frame_i.filter_hit |=> rx_stats_vector_o[B_ADDR])
		else $error("address match lost");

	align_err_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i |=> rx_stats_vector_o[B_ALIGN] == $past(!eng_frame_i.speed_gig
		&& eng_frame_i.odd_nibble && !eng_frame_i.fcs_ok))
		else $error("alignment flag wrong");

	len_short_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i && eng_frame_i.len_is_length && eng_frame_i.len_field < MIN_LEN_FIELD
		&& eng_frame_i.frame_bytes != PAD_FRAME_LEN |=> rx_stats_vector_o[B_LEN])
		else $error("short unpadded frame not flagged");

	len_check_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i && ctrl_r[CTL_LENCHK] && eng_frame_i.len_is_length
		&& eng_frame_i.len_field != eng_frame_i.client_bytes |=> rx_stats_vector_o[B_LEN])
		else $error("length mismatch not flagged");

	bad_opcode_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i |=> rx_stats_vector_o[B_BADOP] == $past(eng_frame_i.frame_ok
		&& eng_frame_i.ctrl_type && eng_frame_i.opcode != PAUSE_OPCODE))
		else $error("bad opcode flag wrong");

	pause_seen_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		rx_stats_valid_o && rx_stats_vector_o[B_PAUSE] |-> $past(eng_frame_i.frame_ok
		&& eng_frame_i.pause_acted && eng_frame_i.opcode == PAUSE_OPCODE))
		else $error("pause flag without acted pause");

	byte_live_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!$past(srst_i) |-> rx_stats_vector_o[B_BYTE] == $past(eng_byte_active_i))
		else $error("byte activity bit stale");

	stats_strobe_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		eng_stats_valid_i ##1 !eng_stats_valid_i |-> rx_stats_valid_o ##1 !rx_stats_valid_o)
		else $error("statistics strobe not one cycle");

	stats_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!rx_stats_valid_o && !$past(srst_i) |-> rx_stats_vector_o[B_ADDR:B_PAUSE]
		== $past(rx_stats_vector_o[B_ADDR:B_PAUSE]))
		else $error("statistics vector changed between strobes");

	// priority bit only exists with the option built in
	if (PFC_EN) begin : g_pfc_chk
		pfc_bit_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
			eng_stats_valid_i |=> rx_stats_vector_o[VEC_W-1] == $past(eng_frame_i.pfc_valid))
			else $error("priority frame flag wrong");
	end

	bus_wait_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read not answered in one wait cycle");

	irq_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$past(eng_stats_valid_i) && mask_r[IRQ_FRAME] && !$past(srst_i) |-> irq_o)
		else $error("unmasked frame event gave no interrupt");

endmodule // rxst_top

/* File: inc/rxst_pkg.sv */
// rxst_pkg: shared constants and carrier types of the receive stream and statistics block
package rxst_pkg;

	// ****************************************
	// statistics vector layout
	// ****************************************
	localparam int RXST_FULL_W = 29;
	localparam int RXST_BASE_W = 28;
	localparam int RXST_LOW_W = 22;
	localparam int B_PFC = 28;
	localparam int B_ADDR = 27;
	localparam int B_ALIGN = 26;
	localparam int B_LEN = 25;
	localparam int B_BADOP = 24;
	localparam int B_PAUSE = 23;
	localparam int B_BYTE = 22;

	// ****************************************
	// frame field values
	// ****************************************
	localparam logic [15:0] MIN_LEN_FIELD = 16'h002E;
	localparam logic [15:0] PAD_FRAME_LEN = 16'h0040;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int AW = 5;
	localparam logic [AW-1:0] REG_CTRL = 5'h00;
	localparam logic [AW-1:0] REG_STATUS = 5'h04;
	localparam logic [AW-1:0] REG_MASK = 5'h08;
	localparam logic [AW-1:0] REG_STATS = 5'h0C;
	localparam logic [AW-1:0] REG_COUNT = 5'h10;
	localparam int CTL_LENCHK = 0;
	localparam int CTL_PROMISC = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_PAUSE = 2;
	localparam int IRQ_BADOP = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic last;
		logic err;
	} rxst_byte_t;

	typedef struct packed {
		logic frame_ok;
		logic fcs_ok;
		logic odd_nibble;
		logic speed_gig;
		logic len_is_length;
		logic [15:0] len_field;
		logic [15:0] client_bytes;
		logic [15:0] frame_bytes;
		logic ctrl_type;
		logic [15:0] opcode;
		logic da_ctrl_mcast;
		logic da_station;
		logic pause_acted;
		logic pfc_valid;
		logic filter_hit;
		logic [RXST_LOW_W-1:0] low_stats;
	} rxst_frame_t;

	typedef struct packed {
		logic priority_flow_control;
		logic addr;
		logic align;
		logic len;
		logic badop;
		logic pause;
	} rxst_flags_t;

endpackage

/* File: tb/rxst_client_model.sv */
// rxst_client_model: client logic that consumes received frames and tallies them
`timescale 1ns/1ns
module rxst_client_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// audio/video receive stream
	input wire logic [7:0] byte_i,
	input wire logic qual_i,
	input wire logic end_i,
	input wire logic err_i,
	// tallies
	output logic [7:0] frames_o,
	output logic [7:0] len_o,
	output logic [7:0] sum_o,
	output logic err_o,
	output logic [7:0] viol_o
);
	logic [7:0] cnt_r;
	logic [7:0] acc_r;
	// ****************************************
	// frame collection
	// ****************************************
	// bytes count on the high qualifier only, never on byte activity
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cnt_r <= 8'h00;
			acc_r <= 8'h00;
			frames_o <= 8'h00;
			len_o <= 8'h00;
			sum_o <= 8'h00;
			err_o <= 1'b0;
		end else if (qual_i) begin
			cnt_r <= end_i ? 8'h00 : cnt_r + 8'h01;
			acc_r <= end_i ? 8'h00 : acc_r ^ byte_i;
			if (end_i) begin
				frames_o <= frames_o + 8'h01;
				len_o <= cnt_r + 8'h01;
				sum_o <= acc_r ^ byte_i;
				err_o <= err_i;
			end
		end
	end
	// end or error flags without a qualified final byte are stream faults
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			viol_o <= 8'h00;
		end else if ((err_i && !end_i) || (end_i && !qual_i)) begin
			viol_o <= viol_o + 8'h01;
		end
	end
endmodule // rxst_client_model

/* File: tb/tb_rxst_top.sv */
// tb_rxst_top: self-checking bench of the receive stream and statistics block
`timescale 1ns/1ns
module tb_rxst_top import rxst_pkg::*; ;
	logic ref_clk_i;
	logic srst_i;
	rxst_byte_t eng_byte_i;
	logic eng_byte_active_i;
	logic eng_stats_valid_i;
	rxst_frame_t eng_frame_i;
	logic [7:0] av_data;
	logic av_qual;
	logic av_end;
	logic av_err;
	logic [28:0] rx_stats_vector_o;
	logic rx_stats_valid_o;
	logic [AW-1:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [7:0] frames;
	logic [7:0] flen;
	logic [7:0] fsum;
	logic ferr;
	logic [7:0] viol;
	logic [31:0] rd_q;
	logic [28:0] last_vec;
	int errors = 0;
	int n_compared = 0;
	// ****************************************
	// design and client
	// ****************************************
	rxst_top #(.PFC_EN(1'b1), .FILTER_EN(1'b1)) i_rxst_top (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.eng_byte_i(eng_byte_i), .eng_byte_active_i(eng_byte_active_i), .eng_stats_valid_i(eng_stats_valid_i),
		.eng_frame_i(eng_frame_i), .av_rx_byte_out_o(av_data), .av_rx_byte_qualifier_o(av_qual),
		.av_rx_frame_end_o(av_end), .av_rx_frame_error_o(av_err), .rx_stats_vector_o(rx_stats_vector_o),
		.rx_stats_valid_o(rx_stats_valid_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
	rxst_client_model i_rxst_client_model (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .byte_i(av_data),
		.qual_i(av_qual), .end_i(av_end), .err_i(av_err), .frames_o(frames), .len_o(flen), .sum_o(fsum),
		.err_o(ferr), .viol_o(viol));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// wait for the rising edge that samples waitrequest low; read data is taken at that edge
	task automatic bus_wait();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 100);
		rd_q = avs_readdata_o;
		chk("bus answer", 32'h0, 32'(avs_waitrequest_o));
	endtask
	task automatic bus_wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_write_i <= 1'b1;
		bus_wait();
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic bus_rd(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		bus_wait();
		avs_read_i <= 1'b0;
		chk(nm, e, rd_q);
		@(posedge ref_clk_i);
	endtask
	task automatic irq_is(input logic e);
		@(negedge ref_clk_i);
		chk("irq", 32'(e), 32'(irq_o));
		@(posedge ref_clk_i);
	endtask
	// bytes of one frame; an error rides on the first byte, the last one too for a one byte frame
	task automatic send_frame(input int n, input logic [7:0] b, input logic er);
		for (int i = 0; i < n; i++) begin
			eng_byte_i <= '{data: b + 8'(i), valid: 1'b1, last: (i == n - 1), err: er && (i == 0)};
			@(posedge ref_clk_i);
		end
	endtask
	function automatic rxst_frame_t mk(input int k);
		rxst_frame_t f;
		f = '0;
		f.frame_ok = 1'b1;
		f.fcs_ok = 1'b1;
		f.filter_hit = 1'b1;
		f.len_field = 16'h0800;
		f.low_stats = 22'h2A5A50 + 22'(k);
		f.ctrl_type = (k >= 6 && k <= 9);
		f.opcode = (k == 6) ? 16'h0002 : PAUSE_OPCODE;
		f.len_is_length = (k >= 3 && k <= 5) || k == 10;
		f.len_field = (k == 3) ? 16'h0064 : (k == 4) ? 16'h002E : (k == 5) ? 16'h002D : f.len_field;
		f.len_field = (k == 10) ? 16'h000A : f.len_field;
		f.client_bytes = (k == 3) ? 16'h0063 : f.len_field;
		f.frame_bytes = (k == 10) ? PAD_FRAME_LEN : 16'h0041;
		f.pfc_valid = (k == 0);
		f.filter_hit = (k != 1);
		f.odd_nibble = (k == 1 || k == 2);
		f.fcs_ok = !(k == 1 || k == 2);
		f.speed_gig = (k == 2);
		f.da_ctrl_mcast = (k == 7);
		f.da_station = (k == 8 || k == 9);
		f.pause_acted = (k == 7 || k == 9);
		return f;
	endfunction
	function automatic logic [28:0] exp_vec(input rxst_frame_t f, input logic lc, input logic pm);
		logic [28:0] e;
		e = '0;
		e[21:0] = f.low_stats;
		e[B_PFC] = f.pfc_valid;
		e[B_ADDR] = pm | f.filter_hit;
		e[B_ALIGN] = ~f.speed_gig & f.odd_nibble & ~f.fcs_ok;
		e[B_LEN] = f.len_is_length & ((lc & (f.len_field != f.client_bytes)) |
			((f.len_field < MIN_LEN_FIELD) & (f.frame_bytes != PAD_FRAME_LEN)));
		e[B_BADOP] = f.frame_ok & f.ctrl_type & (f.opcode != PAUSE_OPCODE);
		e[B_PAUSE] = f.frame_ok & f.ctrl_type & (f.opcode == PAUSE_OPCODE) & (f.da_ctrl_mcast | f.da_station) &
			f.pause_acted;
		return e;
	endfunction
	// one strobe, then the vector is checked on its valid cycle and the cycle after
	task automatic run_stat(input int k, input logic lc, input logic pm);
		logic [28:0] e;
		e = exp_vec(mk(k), lc, pm);
		eng_frame_i <= mk(k);
		eng_stats_valid_i <= 1'b1;
		eng_byte_active_i <= k[0];
		@(posedge ref_clk_i);
		eng_stats_valid_i <= 1'b0;
		eng_byte_active_i <= ~k[0];
		e[B_BYTE] = k[0];
		@(negedge ref_clk_i);
		chk("stats valid", 32'h1, 32'(rx_stats_valid_o));
		chk("stats vector", 32'(e), 32'(rx_stats_vector_o));
		@(posedge ref_clk_i);
		e[B_BYTE] = ~k[0];
		@(negedge ref_clk_i);
		chk("stats valid low", 32'h0, 32'(rx_stats_valid_o));
		chk("stats held", 32'(e), 32'(rx_stats_vector_o));
		@(posedge ref_clk_i);
		last_vec = e;
	endtask
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// clock, tests and watchdog
	// ****************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		errors++;
		conclude();
	end
	initial begin
		srst_i = 1'b1;
		eng_byte_i = '0;
		eng_byte_active_i = 1'b0;
		eng_stats_valid_i = 1'b0;
		eng_frame_i = '0;
		avs_address_i = '0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_byteenable_i = 4'hF;
		avs_writedata_i = 32'h0;
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk("vector width", 32'(RXST_FULL_W), 32'($bits(i_rxst_top.rx_stats_vector_o)));
		bus_rd("ctrl reset", REG_CTRL, 32'h00000001);
		bus_rd("mask reset", REG_MASK, 32'h00000000);
		bus_rd("status reset", REG_STATUS, 32'h00000000);
		bus_wr(REG_CTRL, 32'h00000000, 4'h0);
		bus_rd("ctrl kept", REG_CTRL, 32'h00000001);
		bus_wr(5'h14, 32'hFFFFFFFF, 4'hF);
		bus_rd("unmapped", 5'h14, 32'h00000000);
		// back to back frames; the one byte frame errs on its final byte, the last frame on its first byte
		send_frame(5, 8'h10, 1'b0);
		send_frame(1, 8'h20, 1'b1);
		send_frame(3, 8'h30, 1'b1);
		eng_byte_i <= '0;
		repeat (3) @(posedge ref_clk_i);
		chk("frames", 32'h3, 32'(frames));
		chk("frame length", 32'h3, 32'(flen));
		chk("frame data", 32'(8'h30 ^ 8'h31 ^ 8'h32), 32'(fsum));
		chk("frame error", 32'h1, 32'(ferr));
		chk("stream faults", 32'h0, 32'(viol));
		for (int k = 0; k <= 10; k++) begin
			run_stat(k, 1'b1, 1'b0);
		end
		bus_wr(REG_CTRL, 32'h00000002, 4'hF);
		run_stat(1, 1'b0, 1'b1);
		run_stat(3, 1'b0, 1'b1);
		eng_byte_active_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		last_vec[B_BYTE] = 1'b0;
		bus_wr(REG_STATS, 32'hFFFFFFFF, 4'hF);
		bus_rd("stats register", REG_STATS, 32'(last_vec));
		bus_rd("frame count", REG_COUNT, 32'h0000000D);
		bus_rd("status events", REG_STATUS, 32'h0000000F);
		irq_is(1'b0);
		bus_wr(REG_MASK, 32'h00000004, 4'hF);
		irq_is(1'b1);
		bus_wr(REG_STATUS, 32'h00000004, 4'hF);
		irq_is(1'b0);
		bus_rd("status cleared", REG_STATUS, 32'h0000000B);
		bus_wr(REG_MASK, 32'h0000000F, 4'hF);
		irq_is(1'b1);
		bus_wr(REG_STATUS, 32'h0000000B, 4'hF);
		irq_is(1'b0);
		conclude();
	end
endmodule // tb_rxst_top
